// File: rtl/bsd_consts.svh
// Offsets, field positions and limits of the bitmap setup decoder
`ifndef BSD_CONSTS_SVH
`define BSD_CONSTS_SVH

// Opcodes in bits 31:24
`define BSD_OP_LAYOUT      8'h07
`define BSD_OP_SIZE        8'h08
`define BSD_OP_SOURCE      8'h01
`define BSD_OP_HANDLE      8'h05
// Field positions and limits
`define BSD_FMT_HI         23
`define BSD_FMT_LO         19
`define BSD_STRIDE_HI      18
`define BSD_STRIDE_LO      9
`define BSD_LHEIGHT_HI     8
`define BSD_FILTER_BIT     20
`define BSD_WRAPX_BIT      19
`define BSD_WRAPY_BIT      18
`define BSD_WIDTH_HI       17
`define BSD_WIDTH_LO       9
`define BSD_ADDR_HI        19
`define BSD_HANDLE_HI      4
`define BSD_FMT_MAX        5'h0b
`define BSD_BAR_MAX        9'h100
// Register offsets (byte addresses) and handle count
`define BSD_REG_CMD        8'h00
`define BSD_REG_HANDLE     8'h04
`define BSD_REG_STATUS     8'h08
`define BSD_REG_LAYOUT     8'h0c
`define BSD_REG_SIZE       8'h10
`define BSD_REG_SOURCE     8'h14
`define BSD_REG_RD_HANDLE  8'h18
`define BSD_REG_PIXEL      8'h1c
`define BSD_REG_SAMPLE     8'h20
`define BSD_REG_SAMPLE_XY  8'h24
`define BSD_REG_COLOUR     8'h28
`define BSD_NUM_HANDLES    32

`endif

// File: rtl/bsd_pkg.sv
// Types of the bitmap setup decoder
package bsd_pkg;

  typedef enum logic [3:0] {
    fmt_a1_rgb5        = 4'h0,
    lum_1bit_fmt       = 4'h1,
    lum_4bit_fmt       = 4'h2,
    lum_8bit_fmt       = 4'h3,
    fmt_r3g3b2         = 4'h4,
    fmt_a2_rgb2        = 4'h5,
    fmt_a4_rgb4        = 4'h6,
    fmt_r5g6b5         = 4'h7,
    indexed_colour_fmt = 4'h8,
    char_cell_fmt      = 4'h9,
    attr_char_cell_fmt = 4'ha,
    column_chart_fmt   = 4'hb
  } bsd_fmt_t;

  typedef struct packed {
    logic [4:0] fmt;
    logic [9:0] stride;
    logic [8:0] height;
  } bsd_layout_t;

  typedef struct packed {
    logic       bilinear;
    logic       wrap_x;
    logic       wrap_y;
    logic [8:0] width;
    logic [8:0] height;
  } bsd_size_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        read_pending;
    logic        write_pending;
    logic [7:0]  addr;
    logic [4:0]  handle;
    logic [4:0]  rd_handle;
    logic [31:0] pixel;
    logic [2:0]  sample_x;
    logic [8:0]  sample_y;
    logic        bad_fmt;
    logic        unknown_op;
    logic        bar_oversize;
  } bsd_state_t;

endpackage

// File: rtl/bsd_decoder.sv
// Bitmap setup command decoder with per-handle storage and pixel unpacker
`timescale 1ns/1ps
`default_nettype none
`include "bsd_consts.svh"

module bsd_decoder
  import bsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Current handle settings to the renderer
  output bsd_layout_t      layout_out,
  output bsd_size_t        size_out,
  output logic [19:0]      source_out,
  // Glyph font handle for character formats
  output logic [4:0]       font_handle_out
);

  // ==========================================================
  // Per-handle storage
  // ==========================================================
  bsd_layout_t layout_mem_q [`BSD_NUM_HANDLES];
  bsd_size_t   size_mem_q   [`BSD_NUM_HANDLES];
  logic [19:0] source_mem_q [`BSD_NUM_HANDLES];

  bsd_state_t  state_q;
  bsd_state_t  state_d;

  logic        cmd_wr;
  logic [7:0]  opcode;
  assign cmd_wr = state_q.write_pending && (state_q.addr == `BSD_REG_CMD);
  assign opcode = hwdata_in[31:24];

  // ==========================================================
  // Command word fields
  // ==========================================================
  // Fields are cut from the data phase word; only the strobes qualify them
  logic        is_layout;
  logic        is_size;
  logic        is_source;
  logic        is_handle;
  logic        is_known;
  logic [4:0]  cmd_fmt;
  logic [4:0]  cmd_handle;
  logic [19:0] cmd_addr;
  bsd_layout_t cmd_layout;
  bsd_size_t   cmd_size;

  assign is_layout  = cmd_wr && (opcode == `BSD_OP_LAYOUT);
  assign is_size    = cmd_wr && (opcode == `BSD_OP_SIZE);
  assign is_source  = cmd_wr && (opcode == `BSD_OP_SOURCE);
  assign is_handle  = cmd_wr && (opcode == `BSD_OP_HANDLE);
  assign is_known   = is_layout || is_size || is_source || is_handle;
  assign cmd_fmt    = hwdata_in[`BSD_FMT_HI:`BSD_FMT_LO];
  assign cmd_handle = hwdata_in[`BSD_HANDLE_HI:0];
  // Reserved bits 23:20 are dropped here
  assign cmd_addr   = hwdata_in[`BSD_ADDR_HI:0];

  always_comb begin
    cmd_layout.fmt    = cmd_fmt;
    cmd_layout.stride = hwdata_in[`BSD_STRIDE_HI:`BSD_STRIDE_LO];
    cmd_layout.height = hwdata_in[`BSD_LHEIGHT_HI:0];
    cmd_size.bilinear = hwdata_in[`BSD_FILTER_BIT];
    cmd_size.wrap_x   = hwdata_in[`BSD_WRAPX_BIT];
    cmd_size.wrap_y   = hwdata_in[`BSD_WRAPY_BIT];
    cmd_size.width    = hwdata_in[`BSD_WIDTH_HI:`BSD_WIDTH_LO];
    cmd_size.height   = hwdata_in[`BSD_LHEIGHT_HI:0];
  end

  // ==========================================================
  // Per-handle next values
  // ==========================================================
  bsd_layout_t layout_mem_d [`BSD_NUM_HANDLES];
  bsd_size_t   size_mem_d   [`BSD_NUM_HANDLES];
  logic [19:0] source_mem_d [`BSD_NUM_HANDLES];

  genvar gi;
  generate
    for (gi = 0; gi < `BSD_NUM_HANDLES; gi++) begin : g_handle
      logic hit;
      // Only the current handle's entry moves; the rest hold
      assign hit = (state_q.handle == 5'(gi));
      always_comb begin
        layout_mem_d[gi] = layout_mem_q[gi];
        size_mem_d[gi]   = size_mem_q[gi];
        source_mem_d[gi] = source_mem_q[gi];
        if (hit && is_layout) begin
          layout_mem_d[gi] = cmd_layout;
        end
        if (hit && is_size) begin
          size_mem_d[gi] = cmd_size;
        end
        if (hit && is_source) begin
          source_mem_d[gi] = cmd_addr;
        end
      end
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          layout_mem_q[gi] <= '0;
          size_mem_q[gi]   <= '0;
          source_mem_q[gi] <= '0;
        end else begin
          layout_mem_q[gi] <= layout_mem_d[gi];
          size_mem_q[gi]   <= size_mem_d[gi];
          source_mem_q[gi] <= source_mem_d[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pixel unpacker
  // ==========================================================
  // Sample word holds raw memory bytes, byte 0 in bits 7:0
  bsd_layout_t rd_layout;
  bsd_size_t   rd_size;
  logic [7:0]  b0;
  logic [15:0] w16;
  logic [31:0] argb;
  logic        opaque;
  logic [7:0]  ch_a;
  logic [7:0]  ch_r;
  logic [7:0]  ch_g;
  logic [7:0]  ch_b;
  logic [3:0]  nib;

  assign rd_layout = layout_mem_q[state_q.rd_handle];
  assign rd_size   = size_mem_q[state_q.rd_handle];
  assign b0        = state_q.pixel[7:0];
  assign w16       = state_q.pixel[15:0];

  function automatic logic [7:0] widen(input logic [7:0] v, input int bits);
    logic [7:0] r;
    r = '0;
    unique case (bits)
      1: r = {8{v[0]}};
      2: r = {4{v[1:0]}};
      3: r = {v[2:0], v[2:0], v[2:1]};
      4: r = {2{v[3:0]}};
      5: r = {v[4:0], v[4:2]};
      6: r = {v[5:0], v[5:4]};
      default: r = v;
    endcase
    return r;
  endfunction

  // Luminance formats give white with the level in alpha
  assign nib = state_q.sample_x[0] ? b0[3:0] : b0[7:4];

  always_comb begin
    ch_a   = 8'hff;
    ch_r   = 8'hff;
    ch_g   = 8'hff;
    ch_b   = 8'hff;
    opaque = 1'b0;
    // Full five bits decoded so codes above 15 do not alias valid ones
    unique case (rd_layout.fmt)
      fmt_a1_rgb5: begin
        ch_a = {8{w16[15]}};
        ch_r = widen({3'h0, w16[14:10]}, 5);
        ch_g = widen({3'h0, w16[9:5]}, 5);
        ch_b = widen({3'h0, w16[4:0]}, 5);
      end
      lum_1bit_fmt: begin
        ch_a = {8{b0[3'h7 - state_q.sample_x]}};
      end
      lum_4bit_fmt: begin
        ch_a = widen({4'h0, nib}, 4);
      end
      lum_8bit_fmt: begin
        ch_a = b0;
      end
      fmt_r3g3b2: begin
        ch_r = widen({5'h0, b0[7:5]}, 3);
        ch_g = widen({5'h0, b0[4:2]}, 3);
        ch_b = widen({6'h0, b0[1:0]}, 2);
      end
      fmt_a2_rgb2: begin
        ch_a = widen({6'h0, b0[7:6]}, 2);
        ch_r = widen({6'h0, b0[5:4]}, 2);
        ch_g = widen({6'h0, b0[3:2]}, 2);
        ch_b = widen({6'h0, b0[1:0]}, 2);
      end
      fmt_a4_rgb4: begin
        ch_a = widen({4'h0, w16[15:12]}, 4);
        ch_r = widen({4'h0, w16[11:8]}, 4);
        ch_g = widen({4'h0, w16[7:4]}, 4);
        ch_b = widen({4'h0, w16[3:0]}, 4);
      end
      fmt_r5g6b5: begin
        ch_r = widen({3'h0, w16[15:11]}, 5);
        ch_g = widen({2'h0, w16[10:5]}, 6);
        ch_b = widen({3'h0, w16[4:0]}, 5);
      end
      // Table entry as written to the pixel register, alpha in byte 3
      indexed_colour_fmt: begin
        {ch_a, ch_r, ch_g, ch_b} = state_q.pixel;
      end
      // Glyph index only; font bitmap lookup lives in the rasteriser
      char_cell_fmt: begin
        {ch_a, ch_r, ch_g, ch_b} = {24'h0, b0};
      end
      attr_char_cell_fmt: begin
        {ch_a, ch_r, ch_g, ch_b} = {16'h0, w16};
      end
      column_chart_fmt: begin
        opaque = ({1'b0, b0} < state_q.sample_y);
        ch_a   = {8{opaque}};
      end
      default: begin
        {ch_a, ch_r, ch_g, ch_b} = 32'h0;
      end
    endcase
  end

  assign argb = {ch_a, ch_r, ch_g, ch_b};

  // ==========================================================
  // Bus slave and status
  // ==========================================================
  logic addr_phase;
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;

  // Over-size chart checked on the drawn size of the current handle
  logic chart_cur;
  logic chart_wide;
  logic chart_tall;
  assign chart_cur  = (layout_mem_q[state_q.handle].fmt == 5'(column_chart_fmt));
  assign chart_wide = ({1'b0, size_mem_q[state_q.handle].width} > 10'(`BSD_BAR_MAX));
  assign chart_tall = ({1'b0, size_mem_q[state_q.handle].height} > 10'(`BSD_BAR_MAX));

  always_comb begin
    state_d = state_q;
    state_d.read_pending  = 1'b0;
    state_d.write_pending = 1'b0;
    if (addr_phase) begin
      state_d.addr          = haddr_in;
      state_d.read_pending  = !hwrite_in;
      state_d.write_pending = hwrite_in;
    end
    if (state_q.write_pending) begin
      unique case (state_q.addr)
        `BSD_REG_CMD: begin
          if (is_handle) begin
            state_d.handle = cmd_handle;
          end
        end
        `BSD_REG_HANDLE:    state_d.handle    = hwdata_in[4:0];
        `BSD_REG_RD_HANDLE: state_d.rd_handle = hwdata_in[4:0];
        `BSD_REG_PIXEL:     state_d.pixel     = hwdata_in;
        `BSD_REG_SAMPLE_XY: begin
          state_d.sample_x = hwdata_in[2:0];
          state_d.sample_y = hwdata_in[24:16];
        end
        // Write one to clear; bad_fmt and unknown_op raised by command writes, bar_oversize by the current handle's stored size
        `BSD_REG_STATUS: begin
          if (hwdata_in[0]) state_d.bad_fmt = 1'b0;
          if (hwdata_in[1]) state_d.unknown_op = 1'b0;
          if (hwdata_in[2]) state_d.bar_oversize = 1'b0;
        end
        default: ;
      endcase
    end
    // Flags set after the clear so that a set in the same cycle wins
    if (is_layout && (cmd_fmt > `BSD_FMT_MAX)) begin
      state_d.bad_fmt = 1'b1;
    end
    if (cmd_wr && !is_known) begin
      state_d.unknown_op = 1'b1;
    end
    if (chart_cur && (chart_wide || chart_tall)) begin
      state_d.bar_oversize = 1'b1;
    end
    state_d.hrdata = '0;
    if (addr_phase && !hwrite_in) begin
      unique case (haddr_in)
        `BSD_REG_HANDLE:    state_d.hrdata = {27'h0, state_q.handle};
        `BSD_REG_STATUS:    state_d.hrdata = {29'h0, state_q.bar_oversize,
                                              state_q.unknown_op, state_q.bad_fmt};
        `BSD_REG_LAYOUT:    state_d.hrdata = {8'h0, rd_layout};
        `BSD_REG_SIZE:      state_d.hrdata = {11'h0, rd_size};
        `BSD_REG_SOURCE:    state_d.hrdata = {12'h0, source_mem_q[state_q.rd_handle]};
        `BSD_REG_RD_HANDLE: state_d.hrdata = {27'h0, state_q.rd_handle};
        `BSD_REG_PIXEL:     state_d.hrdata = state_q.pixel;
        `BSD_REG_SAMPLE:    state_d.hrdata = argb;
        `BSD_REG_SAMPLE_XY: state_d.hrdata = {7'h0, state_q.sample_y, 13'h0, state_q.sample_x};
        `BSD_REG_COLOUR:    state_d.hrdata = {31'h0, opaque};
        default:            state_d.hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign hrdata_out      = state_q.hrdata;
  assign hreadyout_out   = 1'b1;
  assign hresp_out       = 1'b0;
  assign layout_out      = layout_mem_q[state_q.handle];
  assign size_out        = size_mem_q[state_q.handle];
  assign source_out      = source_mem_q[state_q.handle];
  // Font for character formats always comes from built-in handle 16
  assign font_handle_out = 5'h10;

endmodule
`default_nettype wire

// File: dv/bsd_decoder_assertions.sv
// Port-level checks of the bitmap setup decoder
`timescale 1ns/1ps
`default_nettype none
module bsd_checker
  import bsd_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic [7:0]  haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // Renderer side
  input wire bsd_layout_t layout_out,
  input wire bsd_size_t   size_out,
  input wire logic [19:0] source_out,
  input wire logic [4:0]  font_handle_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic ap;
  logic cw;
  assign ap = hsel_in && htrans_in[1] && hready_in;
  assign cw = ap && hwrite_in && haddr_in == 8'h00;
  // ==========================================
  // Bus and decode
  a_zero_wait_okay: assert property (hreadyout_out && !hresp_out) else $error("bus stalled or errored");
  a_rdata_idle: assert property (!(ap && !hwrite_in) |=> hrdata_out == 32'h0) else $error("stray read data");
  a_layout_load: assert property (
    cw ##1 hwdata_in[31:24] == 8'h07 |=> layout_out == $past(hwdata_in[23:0])) else $error("layout not loaded");
  a_size_load: assert property (
    cw ##1 hwdata_in[31:24] == 8'h08 |=> size_out == $past(hwdata_in[20:0])) else $error("size not loaded");
  a_source_load: assert property (
    cw ##1 hwdata_in[31:24] == 8'h01 |=> source_out == $past(hwdata_in[19:0])) else $error("source not loaded");
  a_other_op_inert: assert property (
    cw ##1 !(hwdata_in[31:24] inside {8'h01, 8'h05, 8'h07, 8'h08})
    |=> $stable(layout_out) && $stable(size_out) && $stable(source_out)) else $error("foreign opcode stored");
  a_reset_clear: assert property (disable iff (1'b0)
    reset_in |=> layout_out == 24'h0 && source_out == 20'h0 && size_out == 21'h0) else $error("state kept in reset");
  a_font_fixed: assert property (font_handle_out == 5'h10) else $error("wrong font handle");
endmodule
`default_nettype wire

// File: dv/bsd_host.sv
// Host model issuing single word transfers to the decoder
`timescale 1ns/1ps
`default_nettype none
module bsd_host (
  // Bus master
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic [7:0]       haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 8'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
  end
  // Called just after an edge; waits on hready, never a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    @(posedge clk_in);
    while (!hready_in) @(posedge clk_in);
    htrans_out <= 2'h0;
    hwdata_out <= w ? d : ~hwdata_out; // Whole words as given on writes; on reads the previous word inverted
    @(posedge clk_in);
    while (!hready_in) @(posedge clk_in);
    q = hrdata_in;
  endtask
endmodule
`default_nettype wire

// File: dv/bsd_decoder_bench.sv
// Self-checking bench of the bitmap setup decoder
`timescale 1ns/1ps
`default_nettype none
module bsd_decoder_bench;
  import bsd_pkg::*;
  logic        clk_in, reset_in, hsel, hwrite, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  wire logic   hready;
  bsd_layout_t layout;
  bsd_size_t   size;
  logic [19:0] source;
  int          n_fail, checks;
  int          cycles = 0;
  // Unpack table: format, x, raw sample, expected ARGB
  logic [4:0]  uf [13] = '{5'h0, 5'h1, 5'h1, 5'h2, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9, 5'ha};
  logic [2:0]  ux [13] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [31:0] up [13] = '{32'h801f, 32'h80, 32'h80, 32'h5a, 32'h5a, 32'h5a, 32'he0, 32'he4, 32'h1234,
                           32'hf800, 32'h11223344, 32'h41, 32'h1f41};
  logic [31:0] ue [13] = '{32'hff0000ff, 32'hffffffff, 32'h00ffffff, 32'h55ffffff, 32'haaffffff,
                           32'h5affffff, 32'hffff0000, 32'hffaa5500, 32'h11223344, 32'hffff0000, 32'h11223344,
                           32'h41, 32'h1f41};
  bsd_decoder dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .layout_out(layout), .size_out(size), .source_out(source),
    .font_handle_out());
  bsd_host host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lay(input logic [4:0] f, input logic [9:0] s, input logic [8:0] h);
    lay = {8'h07, f, s, h};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    reset_in = 1'b1;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rdc("status", 8'h08, 32'h0);
    wr(8'h00, 32'h05000003);
    wr(8'h00, lay(5'h07, 10'h100, 9'h040)); // Stride in bytes, a power of two
    wr(8'h00, {8'h08, 3'h0, 3'h6, 9'h0a0, 9'h078});
    wr(8'h00, 32'h010abcde); // Two-byte aligned
    @(posedge clk_in);
    check("layout", {8'h0, layout}, 32'h003a0040);
    check("size", {11'h0, size}, {11'h0, 3'h6, 9'h0a0, 9'h078});
    check("source", {12'h0, source}, 32'h000abcde);
    wr(8'h00, 32'h0500001f);
    wr(8'h00, lay(5'h03, 10'h001, 9'h001));
    wr(8'h00, 32'h09000000);
    rdc("unknown op", 8'h08, 32'h2);
    wr(8'h08, 32'h2);
    wr(8'h18, 32'h3);
    rdc("kept layout", 8'h0c, 32'h003a0040);
    rdc("unmapped", 8'h40, 32'h0);
    wr(8'h00, 32'h05000003);
    @(posedge clk_in);
    check("reselect", {8'h0, layout}, 32'h003a0040);
    wr(8'h00, 32'h05000000);
    wr(8'h18, 32'h0);
    for (int f = 0; f < 13; f++) begin
      wr(8'h00, lay(5'(f), 10'h002, 9'h001));
      rdc("format flag", 8'h08, (f > 11) ? 32'h1 : 32'h0);
    end
    wr(8'h08, 32'h1);
    wr(8'h00, lay(5'h0b, 10'h100, 9'h100));
    wr(8'h00, {8'h08, 6'h0, 9'h100, 9'h100});
    @(posedge clk_in);
    rdc("chart 256", 8'h08, 32'h0);
    wr(8'h00, {8'h08, 6'h0, 9'h101, 9'h010});
    // Flag rises one cycle after the drawn size lands
    @(posedge clk_in);
    rdc("chart 257", 8'h08, 32'h4);
    // Flag re-sets while the oversize drawn size stands, so shrink it first
    wr(8'h00, {8'h08, 6'h0, 9'h010, 9'h010});
    wr(8'h08, 32'h4);
    @(posedge clk_in);
    rdc("chart cleared", 8'h08, 32'h0);
    wr(8'h1c, 32'h10);
    wr(8'h24, 32'h00110000);
    rdc("opaque", 8'h28, 32'h1);
    wr(8'h24, 32'h00100000);
    rdc("transparent", 8'h28, 32'h0);
    for (int i = 0; i < 13; i++) begin
      wr(8'h00, lay(uf[i], 10'h002, 9'h001));
      wr(8'h24, {29'h0, ux[i]});
      wr(8'h1c, up[i]);
      rdc("sample", 8'h20, ue[i]);
    end
    // Second reset in mid-run must clear every handle and flag
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rdc("layout reset", 8'h0c, 32'h0);
    rdc("status reset", 8'h08, 32'h0);
    finish_test;
  end
endmodule
bind bsd_decoder bsd_checker chk (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .layout_out(layout_out),
  .size_out(size_out), .source_out(source_out), .font_handle_out(font_handle_out));
`default_nettype wire
